// ---- dpgd_params.svh ----
// constants for the dimming period and group duty block
`ifndef DPGD_PARAMS_SVH
`define DPGD_PARAMS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define DPGD_ADDR_CFG 8'h02
`define DPGD_ADDR_INT_LO 8'h19
`define DPGD_ADDR_INT_HI 8'h1a
`define DPGD_ADDR_GRP_A 8'h1b
`define DPGD_ADDR_GRP_B 8'h1c
`define DPGD_ADDR_DUTY0 8'h1d

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define DPGD_NUM_CH 6
`define DPGD_CH_PER_REG 3
`define DPGD_CFG_PER_LSB 2
`define DPGD_SEL0_LSB 0
`define DPGD_SEL1_LSB 4
`define DPGD_SEL2_LSB 8
`define DPGD_FADE_BIT 12

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define DPGD_RST_WORD 13'h0000
`define DPGD_RST_CFG_PER 2'h0

// -----------------------------------------------------------------
// timing counts, in pwm clock cycles
// -----------------------------------------------------------------
`define DPGD_PERIOD_CYC_0 8192
`define DPGD_PERIOD_CYC_1 4096
`define DPGD_PERIOD_CYC_2 2048
`define DPGD_PERIOD_CYC_3 1024

`endif

// ---- dpgd_pkg.sv ----
// types and decode helpers for the dimming period and group duty block
package dpgd_pkg;

  typedef logic [11:0] dpgd_duty_t;
  typedef logic [2:0] dpgd_sel_t;
  typedef logic [12:0] dpgd_word_t;
  typedef logic [4:0] dpgd_ivl_t;

  // -----------------------------------------------------------------
  // last period index of an update interval
  // -----------------------------------------------------------------
  function automatic dpgd_ivl_t dpgd_ivl_last(input dpgd_sel_t sel);
    dpgd_ivl_t r;
    r = 5'h1f;
    if (sel < 3'h6) begin
      r = 5'((6'h01 << sel) - 6'h01);
    end
    return r;
  endfunction : dpgd_ivl_last

  // -----------------------------------------------------------------
  // pack three selectors into a register word
  // -----------------------------------------------------------------
  function automatic dpgd_word_t dpgd_pack_sel(input dpgd_sel_t s2,
                                               input dpgd_sel_t s1,
                                               input dpgd_sel_t s0);
    return {2'h0, s2, 1'h0, s1, 1'h0, s0};
  endfunction : dpgd_pack_sel

endpackage : dpgd_pkg

// ---- dpgd_chan_if.sv ----
// link between the register side and one channel updater
`timescale 1ns/100ps
interface dpgd_chan_if (
  input wire logic clock
);
  import dpgd_pkg::*;

  logic period_end;
  dpgd_sel_t sel;
  dpgd_duty_t duty_pend;
  logic fade_pend;
  dpgd_duty_t duty_act;
  logic fade_act;
  logic update;

  modport ctrl (
    output period_end,
    output sel,
    output duty_pend,
    output fade_pend,
    input duty_act,
    input fade_act,
    input update
  );

  modport chan (
    input clock,
    input period_end,
    input sel,
    input duty_pend,
    input fade_pend,
    output duty_act,
    output fade_act,
    output update
  );
endinterface : dpgd_chan_if

// ---- dpgd_chan.sv ----
// per channel update interval counter and applied duty value
`timescale 1ns/100ps
module dpgd_chan
  import dpgd_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  dpgd_chan_if.chan cif
);

  dpgd_ivl_t cnt_q;
  dpgd_ivl_t last;
  logic apply;

  // -----------------------------------------------------------------
  // interval decode
  // -----------------------------------------------------------------
  assign last = dpgd_ivl_last(cif.sel); // [RQ1] [RQ2]
  assign apply = cif.period_end && (cnt_q >= last); // [RQ14]

  // -----------------------------------------------------------------
  // period counter within the interval
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= 5'h00;
    end else if (apply) begin
      cnt_q <= 5'h00;
    end else if (cif.period_end) begin
      cnt_q <= 5'(cnt_q + 5'h01); // [RQ1]
    end
  end

  // -----------------------------------------------------------------
  // applied duty and fade
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cif.duty_act <= 12'h000;
      cif.fade_act <= 1'h0;
    end else if (apply) begin
      cif.duty_act <= cif.duty_pend; // [RQ14] [RQ13]
      cif.fade_act <= cif.fade_pend; // [RQ9]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cif.update <= 1'h0;
    end else begin
      cif.update <= apply;
    end
  end

endmodule : dpgd_chan

// ---- dpgd_top.sv ----
// dimming period select, group duty registers and channel duty update
//
// Behaviour
// [RQ1] codes 0-5 update every 1..32 periods
// [RQ2] codes 6 and 7 act as 5
// [RQ3] default period is 8192 pwm clocks
// [RQ4] period length chosen by cfg bits 3:2
// [RQ5] ch5 10:8, ch4 6:4, ch3 2:0
// [RQ6] ch1 6:4, ch0 2:0 selector fields
// [RQ7] group a write copies duty to members
// [RQ8] group b write copies duty to members
// [RQ9] bit 12 of group word enables fade
// [RQ10] one write sets duty and fade together
// [RQ11] members read back exactly the group value
// [RQ12] interval registers read back their selector fields only, group registers as written
// [RQ13] duty is 12 bits, 0 off, fff full
// [RQ14] new duty applies only at interval boundary
`timescale 1ns/100ps
`include "dpgd_params.svh"
module dpgd_top
  import dpgd_pkg::*;
#(
  parameter int PERIOD_CYC_0 = `DPGD_PERIOD_CYC_0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [12:0] reg_wdata,
  output logic [12:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [5:0] group_a_members,
  input wire logic [5:0] group_b_members,
  output logic [5:0][11:0] duty_active,
  output logic [5:0] fade_active,
  output logic [5:0] duty_update,
  output logic period_end
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [1:0] cfg_per_q;
  dpgd_sel_t sel_q [`DPGD_NUM_CH];
  dpgd_word_t grp_a_q;
  dpgd_word_t grp_b_q;
  dpgd_duty_t duty_q [`DPGD_NUM_CH];
  logic fade_q [`DPGD_NUM_CH];
  logic [12:0] per_cnt_q;
  logic [12:0] per_last;
  logic wr_cfg;
  logic wr_lo;
  logic wr_hi;
  logic wr_a;
  logic wr_b;

  assign wr_cfg = reg_wr && (reg_addr == `DPGD_ADDR_CFG);
  assign wr_lo = reg_wr && (reg_addr == `DPGD_ADDR_INT_LO);
  assign wr_hi = reg_wr && (reg_addr == `DPGD_ADDR_INT_HI);
  assign wr_a = reg_wr && (reg_addr == `DPGD_ADDR_GRP_A);
  assign wr_b = reg_wr && (reg_addr == `DPGD_ADDR_GRP_B);

  // -----------------------------------------------------------------
  // period configuration
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_per_q <= `DPGD_RST_CFG_PER;
    end else if (wr_cfg) begin
      cfg_per_q <= reg_wdata[`DPGD_CFG_PER_LSB +: 2]; // [RQ4]
    end
  end

  always_comb begin
    unique case (cfg_per_q)
      2'h0: per_last = 13'(PERIOD_CYC_0 - 1); // [RQ3]
      2'h1: per_last = 13'(`DPGD_PERIOD_CYC_1 - 1);
      2'h2: per_last = 13'(`DPGD_PERIOD_CYC_2 - 1);
      2'h3: per_last = 13'(`DPGD_PERIOD_CYC_3 - 1);
    endcase
  end

  // -----------------------------------------------------------------
  // pwm period counter
  // -----------------------------------------------------------------
  assign period_end = (per_cnt_q >= per_last); // [RQ4]

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      per_cnt_q <= 13'h0000;
    end else if (period_end) begin
      per_cnt_q <= 13'h0000;
    end else begin
      per_cnt_q <= 13'(per_cnt_q + 13'h0001); // [RQ3]
    end
  end

  // -----------------------------------------------------------------
  // update interval selectors
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < `DPGD_NUM_CH; i++) begin
        sel_q[i] <= 3'h0;
      end
    end else begin
      if (wr_lo) begin
        sel_q[0] <= reg_wdata[`DPGD_SEL0_LSB +: 3]; // [RQ6]
        sel_q[1] <= reg_wdata[`DPGD_SEL1_LSB +: 3]; // [RQ6]
        sel_q[2] <= reg_wdata[`DPGD_SEL2_LSB +: 3];
      end
      if (wr_hi) begin
        sel_q[3] <= reg_wdata[`DPGD_SEL0_LSB +: 3]; // [RQ5]
        sel_q[4] <= reg_wdata[`DPGD_SEL1_LSB +: 3]; // [RQ5]
        sel_q[5] <= reg_wdata[`DPGD_SEL2_LSB +: 3]; // [RQ5]
      end
    end
  end

  // -----------------------------------------------------------------
  // group duty registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      grp_a_q <= `DPGD_RST_WORD;
      grp_b_q <= `DPGD_RST_WORD;
    end else begin
      if (wr_a) begin
        grp_a_q <= reg_wdata; // [RQ12]
      end
      if (wr_b) begin
        grp_b_q <= reg_wdata; // [RQ12]
      end
    end
  end

  // -----------------------------------------------------------------
  // channel duty registers, loaded directly or by a group write
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < `DPGD_NUM_CH; i++) begin
        duty_q[i] <= 12'h000;
        fade_q[i] <= 1'h0;
      end
    end else begin
      for (int i = 0; i < `DPGD_NUM_CH; i++) begin
        if (reg_wr && (reg_addr == 8'(`DPGD_ADDR_DUTY0 + i))) begin
          duty_q[i] <= reg_wdata[11:0]; // [RQ13]
          fade_q[i] <= reg_wdata[`DPGD_FADE_BIT];
        end else if (wr_a && group_a_members[i]) begin
          duty_q[i] <= reg_wdata[11:0]; // [RQ7] [RQ10] [RQ11]
          fade_q[i] <= reg_wdata[`DPGD_FADE_BIT]; // [RQ9] [RQ10]
        end else if (wr_b && group_b_members[i]) begin
          duty_q[i] <= reg_wdata[11:0]; // [RQ8] [RQ10] [RQ11]
          fade_q[i] <= reg_wdata[`DPGD_FADE_BIT]; // [RQ9] [RQ10]
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // channel updaters
  // -----------------------------------------------------------------
  for (genvar g = 0; g < `DPGD_NUM_CH; g++) begin : g_ch
    dpgd_chan_if cif (
      .clock(clock)
    );

    assign cif.period_end = period_end;
    assign cif.sel = sel_q[g];
    assign cif.duty_pend = duty_q[g];
    assign cif.fade_pend = fade_q[g];
    assign duty_active[g] = cif.duty_act;
    assign fade_active[g] = cif.fade_act;
    assign duty_update[g] = cif.update;

    dpgd_chan u_chan (
      .clock(clock),
      .sys_rst(sys_rst),
      .cif(cif.chan)
    );
  end

  // -----------------------------------------------------------------
  // register readback
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rvalid <= 1'h0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 13'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 13'h0000;
      unique case (reg_addr)
        `DPGD_ADDR_CFG: begin
          reg_rdata[`DPGD_CFG_PER_LSB +: 2] <= cfg_per_q;
        end
        `DPGD_ADDR_INT_LO: begin
          reg_rdata <= dpgd_pack_sel(sel_q[2], sel_q[1], sel_q[0]); // [RQ12]
        end
        `DPGD_ADDR_INT_HI: begin
          reg_rdata <= dpgd_pack_sel(sel_q[5], sel_q[4], sel_q[3]); // [RQ12]
        end
        `DPGD_ADDR_GRP_A: begin
          reg_rdata <= grp_a_q; // [RQ12]
        end
        `DPGD_ADDR_GRP_B: begin
          reg_rdata <= grp_b_q; // [RQ12]
        end
        default: begin
          for (int i = 0; i < `DPGD_NUM_CH; i++) begin
            if (reg_addr == 8'(`DPGD_ADDR_DUTY0 + i)) begin
              reg_rdata <= {fade_q[i], duty_q[i]}; // [RQ11]
            end
          end
        end
      endcase
    end
  end

endmodule : dpgd_top

// ---- dpgd_host.sv ----
// host side register access model for the dimming block
`timescale 1ns/100ps
module dpgd_host (
  input wire logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [12:0] reg_wdata,
  input wire logic [12:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 13'h0000;
  end
  // released address and data show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [12:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [12:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clock);
    d = (reg_rvalid === 1'b1) ? reg_rdata : 13'hxxxx;
  endtask : rd
endmodule : dpgd_host

// ---- dpgd_top_chk.sv ----
// assertion checker for the dimming period and group duty block
`timescale 1ns/100ps
module dpgd_top_chk
  import dpgd_pkg::*;
#(
  parameter int PERIOD_CYC_0 = 8192
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [12:0] reg_wdata,
  input wire logic [12:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [5:0] group_a_members,
  input wire logic [5:0] group_b_members,
  input wire logic [5:0][11:0] duty_active,
  input wire logic [5:0] fade_active,
  input wire logic [5:0] duty_update,
  input wire logic period_end
);
  logic [1:0] cfg_q;
  logic seen_q;
  int unsigned cnt_q;
  int unsigned len;
  logic [12:0] grp_a_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) cfg_q <= 2'h0;
    else if (reg_wr && reg_addr == 8'h02) cfg_q <= reg_wdata[3:2];
  end
  always_ff @(posedge clock) begin
    if (sys_rst || (reg_wr && reg_addr == 8'h02)) begin
      cnt_q <= 0;
      seen_q <= 1'b0;
    end else if (period_end) begin
      cnt_q <= 0;
      seen_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) grp_a_q <= 13'h0000;
    else if (reg_wr && reg_addr == 8'h1b) grp_a_q <= reg_wdata;
  end
  assign len = (cfg_q == 2'h0) ? PERIOD_CYC_0 : (32'h2000 >> cfg_q);
  sequence rd_at(logic [7:0] a);
    reg_rd && !reg_wr && reg_addr == a;
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  rvalid_follow_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe gave no valid");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("valid without read strobe");
  group_back_a: assert property (rd_at(8'h1b) |=> reg_rdata == grp_a_q)
    else $error("group a read differs from last write");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 8'h22 |=>
    reg_rdata == 13'h0000) else $error("unmapped read not zero");
  reserved_zero_a: assert property (reg_rd &&
    (reg_addr == 8'h19 || reg_addr == 8'h1a) |=>
    (reg_rdata & 13'h1888) == 13'h0000) else $error("reserved bit set");
  period_len_a: assert property (period_end && seen_q |->
    cnt_q == len - 1) else $error("period length wrong");
  duty_hold_a: assert property (!period_end |=> $stable(duty_active)
    && $stable(fade_active)) else $error("duty changed mid period");
  update_cause_a: assert property (|duty_update |-> $past(period_end))
    else $error("update pulse off a boundary");
endmodule : dpgd_top_chk
bind dpgd_top dpgd_top_chk #(.PERIOD_CYC_0(PERIOD_CYC_0)) dpgd_top_chk_inst (
  .clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .group_a_members(group_a_members),
  .group_b_members(group_b_members), .duty_active(duty_active),
  .fade_active(fade_active), .duty_update(duty_update),
  .period_end(period_end));

// ---- tb_top.sv ----
// self-checking bench for the dimming period and group duty block
`timescale 1ns/100ps
module tb_top;
  import dpgd_pkg::*;
  localparam int PCYC = 16;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, period_end;
  logic [7:0] reg_addr;
  logic [12:0] reg_wdata, reg_rdata;
  logic [5:0] group_a_members = 6'h00;
  logic [5:0] group_b_members = 6'h00;
  logic [5:0][11:0] duty_active;
  logic [5:0] fade_active, duty_update;
  int n_mismatch = 0;
  int check_count = 0;
  int ch, cd, n;
  always #2.5 clock = ~clock;
  dpgd_top #(.PERIOD_CYC_0(PCYC)) dpgd_top_inst (.clock(clock),
    .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .group_a_members(group_a_members),
    .group_b_members(group_b_members), .duty_active(duty_active),
    .fade_active(fade_active), .duty_update(duty_update),
    .period_end(period_end));
  dpgd_host dpgd_host_inst (.clock(clock), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [12:0] exp);
    logic [12:0] d;
    dpgd_host_inst.rd(a, d);
    chk(d, exp);
  endtask : rchk
  task automatic wait_upd(input int c, output int np);
    np = 0;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clock);
      if (duty_update[c] === 1'b1) break;
      if (period_end === 1'b1) np++;
    end
  endtask : wait_upd
  task automatic wait_pe(output int nc);
    nc = 0;
    do begin
      @(posedge clock);
      nc++;
    end while (period_end !== 1'b1 && nc < 20000);
  endtask : wait_pe
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 6; i++) rchk(8'(8'h19 + i), 13'h0000);
    rchk(8'h02, 13'h0000);
    dpgd_host_inst.wr(8'h19, 13'h1fff);
    rchk(8'h19, 13'h0777);
    dpgd_host_inst.wr(8'h1a, 13'h1fff);
    rchk(8'h1a, 13'h0777);
    dpgd_host_inst.wr(8'h40, 13'h1fff);
    rchk(8'h40, 13'h0000);
    for (int c = 0; c < 8; c++) begin
      ch = c % 6;
      cd = 4 * (ch % 3);
      dpgd_host_inst.wr(ch < 3 ? 8'h19 : 8'h1a, 13'(c) << cd);
      dpgd_host_inst.wr(8'(8'h1d + ch), 13'(13'h0100 + c));
      wait_upd(ch, n);
      wait_upd(ch, n);
      chk(13'(n), c > 4 ? 13'h0020 : 13'h0001 << c);
      chk({fade_active[ch], duty_active[ch]}, 13'(13'h0100 + c));
    end
    dpgd_host_inst.wr(8'h19, 13'h0000);
    dpgd_host_inst.wr(8'h1a, 13'h0000);
    group_a_members <= 6'h25;
    group_b_members <= 6'h1a;
    dpgd_host_inst.wr(8'h1c, 13'h1555);
    dpgd_host_inst.wr(8'h1b, 13'h00aa);
    rchk(8'h1b, 13'h00aa);
    rchk(8'h1c, 13'h1555);
    for (int i = 0; i < 6; i++) begin
      rchk(8'(8'h1d + i), group_a_members[i] ? 13'h00aa : 13'h1555);
    end
    wait_upd(0, n);
    for (int i = 0; i < 6; i++) begin
      chk({fade_active[i], duty_active[i]},
        group_a_members[i] ? 13'h00aa : 13'h1555);
    end
    group_a_members <= 6'h3f;
    dpgd_host_inst.wr(8'h1b, 13'h0fff);
    for (int i = 0; i < 6; i++) rchk(8'(8'h1d + i), 13'h0fff);
    for (int p = 1; p < 5; p++) begin
      cd = p % 4;
      dpgd_host_inst.wr(8'h02, 13'h1ff3 | (13'(cd) << 2));
      rchk(8'h02, 13'(cd) << 2);
      wait_pe(n);
      wait_pe(n);
      wait_pe(n);
      chk(13'(n), cd == 0 ? 13'(PCYC) : 13'h1000 >> (cd - 1));
    end
    report_and_stop();
  end
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
